//--- shared/trs_map.svh
// Constant map for the telemetry read slave
`ifndef TRS_MAP_SVH
`define TRS_MAP_SVH

`define TRS_ADDR_HI 4'h4
`define TRS_CMD_READ 8'h21
`define TRS_CMD_CSUM 8'hDF
`define TRS_FILL_BYTE 8'hFF
`define TRS_RSVD_BYTE 8'hAA
`define TRS_BYTE_BITS 4'h8
`define TRS_TX_LEN 7'h41
`define TRS_POS_ZERO 7'h01
`define TRS_POS_SERIAL 7'h34
`define TRS_POS_SERIAL_END 7'h37
`define TRS_POS_ZSUM 7'h3F
`define TRS_POS_LAST 7'h40
`define TRS_IMG_TOP 10'h1F7
`define TRS_CLK_PERIOD_NS 100
`define TRS_SCL_MAX_KHZ 200
`define TRS_SCL_MIN_PERIOD_NS (1000000 / `TRS_SCL_MAX_KHZ)
`define TRS_SCL_MIN_CYC \
    ((`TRS_SCL_MIN_PERIOD_NS + `TRS_CLK_PERIOD_NS - 1) / `TRS_CLK_PERIOD_NS)

`endif

//--- shared/trs_pkg.sv
// Types shared by the telemetry read slave
`default_nettype none
package trs_pkg;
    typedef logic [7:0] trs_byte_t;
    typedef enum {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK,
        ST_CSUM, ST_CSUM_ACK, ST_TX, ST_TX_ACK, ST_IGNORE
    } trs_state_t;
endpackage
`default_nettype wire

//--- shared/trs_stream_if.sv
// Byte stream carrier with valid and ready
`default_nettype none
interface trs_stream_if #(parameter int WIDTH = 8);
    logic [WIDTH-1:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

//--- hw/trs_fifo.sv
// Stream FIFO between frame builder and bus transmitter
`default_nettype none
module trs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    localparam int AW = $clog2(DEPTH)
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    input wire logic flush,
    // Streams
    trs_stream_if.snk in_s,
    trs_stream_if.src out_s
);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic full;
    logic empty;
    logic push;
    logic pop;

    assign empty = (wr_q == rd_q);
    assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    assign push = in_s.valid && !full;
    assign pop = out_s.ready && !empty;
    assign in_s.ready = !full;
    assign out_s.valid = !empty;
    assign out_s.data = mem_q[rd_q[AW-1:0]];

    always_ff @(posedge clock) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_s.data;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn || flush) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

//--- hw/trs_frame_builder.sv
// Builds the 65-byte telemetry answer as a byte stream
`include "trs_map.svh"
`default_nettype none
module trs_frame_builder (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Control
    input wire logic start,
    input wire logic abort,
    input wire trs_pkg::trs_byte_t cmd_code,
    // Telemetry snapshot sources
    input wire logic [15:0] card_temp,
    input wire logic [15:0] main_12v_output_volt,
    input wire logic [15:0] aux_3v3_output_volt,
    input wire logic [15:0] main_12v_output_curr,
    input wire logic [15:0] aux_3v3_output_curr,
    input wire logic [159:0] part_string,
    input wire logic [31:0] serial_bcd,
    input wire logic [15:0] date_code,
    input wire logic [15:0] hw_rev,
    input wire logic [15:0] fw_rev,
    // Output stream
    trs_stream_if.src out_s
);
    logic [503:0] img_q;
    logic active_q;
    logic [6:0] idx_q;
    logic [7:0] sum_q;
    logic [9:0] top_bit;
    logic fire;
    logic [31:0] ser_chk_q;
    logic [7:0] chk_q;

    // Bytes 0..62 in send order, most significant byte first
    always_ff @(posedge clock) begin
        if (start) begin
            img_q <= {cmd_code, 8'h00, card_temp, main_12v_output_volt,
                aux_3v3_output_volt, 64'h0, main_12v_output_curr, aux_3v3_output_curr,
                96'h0, part_string, serial_bcd, date_code, hw_rev, fw_rev,
                `TRS_RSVD_BYTE};
        end
    end

    assign top_bit = `TRS_IMG_TOP - {idx_q, 3'b000};
    assign fire = active_q && out_s.ready;
    assign out_s.valid = active_q;
    // Zero-sum byte, then trailing checksum of the whole frame
    assign out_s.data = (idx_q >= `TRS_POS_ZSUM) ? (8'h00 - sum_q) : img_q[top_bit -: 8];

    always_ff @(posedge clock) begin
        if (!rstn) begin
            active_q <= 1'b0;
            idx_q <= '0;
            sum_q <= '0;
        end else if (start) begin
            active_q <= 1'b1;
            idx_q <= '0;
            sum_q <= '0;
        end else if (abort) begin
            active_q <= 1'b0;
        end else if (fire) begin
            idx_q <= idx_q + 7'h01;
            sum_q <= sum_q + out_s.data;
            if (idx_q == `TRS_POS_LAST) begin
                active_q <= 1'b0;
            end
        end
    end

    // ****************
    // Checking helpers
    // ****************
    always_ff @(posedge clock) begin
        if (!rstn) begin
            ser_chk_q <= '0;
            chk_q <= '0;
        end else if (start) begin
            ser_chk_q <= serial_bcd;
            chk_q <= '0;
        end else if (fire) begin
            chk_q <= chk_q + out_s.data;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    AST_ECHO_CMD: assert property (
        start |=> out_s.valid && out_s.data == $past(cmd_code))
        else $error("frame byte 0 is not the command echo");
    AST_ZERO_BYTE: assert property (
        out_s.valid && idx_q == `TRS_POS_ZERO |-> out_s.data == 8'h00)
        else $error("frame byte 1 is not zero");
    AST_TEMP_ORDER: assert property (
        start |-> ##3 (out_s.data == $past(card_temp[15:8], 3))
        ##1 (out_s.data == $past(card_temp[7:0], 4)))
        else $error("temperature bytes wrong or out of order");
    AST_SERIAL_HI: assert property (
        out_s.valid && idx_q == `TRS_POS_SERIAL |-> out_s.data == ser_chk_q[31:24])
        else $error("serial high digit pair misplaced");
    AST_SERIAL_LO: assert property (
        out_s.valid && idx_q == `TRS_POS_SERIAL_END |-> out_s.data == ser_chk_q[7:0])
        else $error("serial low digit pair misplaced");
    AST_ZERO_SUM: assert property (
        out_s.valid && idx_q == `TRS_POS_ZSUM |-> 8'(chk_q + out_s.data) == 8'h00)
        else $error("frame bytes do not sum to a multiple of 256");
endmodule
`default_nettype wire

//--- hw/trs_telemetry_slave.sv
// Two-wire bus slave answering the telemetry read command
// Functional notes
// - Address is 0100 plus three slot bits
// - Bus clock at most 200 kHz
// - Command 0x21 requests the 64-byte frame
// - Checksum 0xDF then stop; all acknowledged
// - Read address returns 64 bytes plus checksum
// - Byte 0 echoes command, byte 1 zero
// - Bytes 2-3 signed temperature, MSB first
// - Bytes 52-55 packed decimal serial, high first
// - Byte 63 makes bytes 0-63 sum zero
// - Slot bit 2 most, bit 0 least significant
`include "trs_map.svh"
`default_nettype none
module trs_telemetry_slave #(
    parameter int FIFO_DEPTH = 16,
    parameter int SCL_MIN_CYC = `TRS_SCL_MIN_CYC
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // Slot pins
    input wire logic geo_slot_bit2,
    input wire logic geo_slot_bit1,
    input wire logic geo_slot_bit0,
    // Telemetry sources
    input wire logic [15:0] card_temp,
    input wire logic [15:0] main_12v_output_volt,
    input wire logic [15:0] aux_3v3_output_volt,
    input wire logic [15:0] main_12v_output_curr,
    input wire logic [15:0] aux_3v3_output_curr,
    input wire logic [159:0] part_string,
    input wire logic [31:0] serial_bcd,
    input wire logic [15:0] date_code,
    input wire logic [15:0] hw_rev,
    input wire logic [15:0] fw_rev,
    // Status
    output logic frame_ready
);
    logic scl_m, scl_s, scl_p;
    logic sda_m, sda_s, sda_p;
    logic [2:0] slot_m, slot_s;
    logic scl_rise, scl_fall, start_det, stop_det;
    trs_pkg::trs_state_t state_q;
    logic [7:0] shift_q;
    logic [3:0] bit_q;
    logic rw_q;
    trs_pkg::trs_byte_t cmd_q;
    trs_pkg::trs_byte_t tx_q;
    logic [6:0] txcnt_q;
    logic csum_ok_q, armed_q, build_q, flush_q;
    logic sda_oe_n_q, sda_out_q;
    logic addr_hit, byte_done, ack_now, load_now, pop_ok, nack_seen;
    trs_pkg::trs_byte_t next_byte;
    logic [7:0] gap_q;
    logic gap_seen_q;

    trs_stream_if #(.WIDTH(8)) bld_s ();
    trs_stream_if #(.WIDTH(8)) fifo_s ();

    // ************************
    // Pin synchronisers
    // ************************
    always_ff @(posedge clock) begin
        if (!rstn) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_p <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_p <= 1'b1;
            slot_m <= 3'h0;
            slot_s <= 3'h0;
        end else begin
            scl_m <= scl_in;
            scl_s <= scl_m;
            scl_p <= scl_s;
            sda_m <= sda_in;
            sda_s <= sda_m;
            sda_p <= sda_s;
            slot_m <= {geo_slot_bit2, geo_slot_bit1, geo_slot_bit0};
            slot_s <= slot_m;
        end
    end

    assign scl_rise = scl_s && !scl_p;
    assign scl_fall = !scl_s && scl_p;
    assign start_det = scl_s && scl_p && sda_p && !sda_s;
    assign stop_det = scl_s && scl_p && !sda_p && sda_s;

    // ************************
    // Byte decisions
    // ************************
    assign addr_hit = (shift_q[7:1] == {`TRS_ADDR_HI, slot_s});
    assign byte_done = scl_fall && (bit_q == `TRS_BYTE_BITS);
    // Read address only taken once a frame has been requested
    assign ack_now = byte_done && (
        (state_q == trs_pkg::ST_ADDR && addr_hit && (!shift_q[0] || armed_q)) ||
        (state_q == trs_pkg::ST_CMD && shift_q == `TRS_CMD_READ) ||
        (state_q == trs_pkg::ST_CSUM && shift_q == `TRS_CMD_CSUM));
    assign load_now = scl_fall && ((state_q == trs_pkg::ST_ADDR_ACK && rw_q) ||
        state_q == trs_pkg::ST_TX_ACK);
    assign pop_ok = load_now && fifo_s.valid;
    assign fifo_s.ready = pop_ok;
    // Past the frame end the bus reads idle ones
    assign next_byte = pop_ok ? fifo_s.data : `TRS_FILL_BYTE;
    assign nack_seen = (state_q == trs_pkg::ST_TX_ACK) && scl_rise && sda_s;

    // ************************
    // Bus state machine
    // ************************
    always_ff @(posedge clock) begin
        if (!rstn) begin
            state_q <= trs_pkg::ST_IDLE;
            shift_q <= 8'h00;
            bit_q <= 4'h0;
            rw_q <= 1'b0;
            cmd_q <= 8'h00;
            tx_q <= 8'h00;
            txcnt_q <= 7'h00;
        end else if (start_det) begin
            state_q <= trs_pkg::ST_ADDR;
            bit_q <= 4'h0;
            txcnt_q <= 7'h00;
        end else if (stop_det) begin
            state_q <= trs_pkg::ST_IDLE;
        end else begin
            case (state_q)
                trs_pkg::ST_ADDR, trs_pkg::ST_CMD, trs_pkg::ST_CSUM: begin
                    if (scl_rise && bit_q != `TRS_BYTE_BITS) begin
                        shift_q <= {shift_q[6:0], sda_s};
                        bit_q <= bit_q + 4'h1;
                    end else if (byte_done) begin
                        bit_q <= 4'h0;
                        if (!ack_now) begin
                            state_q <= trs_pkg::ST_IGNORE;
                        end else if (state_q == trs_pkg::ST_ADDR) begin
                            state_q <= trs_pkg::ST_ADDR_ACK;
                            rw_q <= shift_q[0];
                        end else if (state_q == trs_pkg::ST_CMD) begin
                            state_q <= trs_pkg::ST_CMD_ACK;
                            cmd_q <= shift_q;
                        end else begin
                            state_q <= trs_pkg::ST_CSUM_ACK;
                        end
                    end
                end
                trs_pkg::ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (rw_q) begin
                            state_q <= trs_pkg::ST_TX;
                            tx_q <= next_byte;
                            bit_q <= 4'h1;
                            txcnt_q <= 7'h01;
                        end else begin
                            state_q <= trs_pkg::ST_CMD;
                        end
                    end
                end
                trs_pkg::ST_CMD_ACK: begin
                    if (scl_fall) begin
                        state_q <= trs_pkg::ST_CSUM;
                    end
                end
                trs_pkg::ST_CSUM_ACK: begin
                    if (scl_fall) begin
                        state_q <= trs_pkg::ST_IGNORE;
                    end
                end
                trs_pkg::ST_TX: begin
                    if (scl_fall) begin
                        if (bit_q == `TRS_BYTE_BITS) begin
                            state_q <= trs_pkg::ST_TX_ACK;
                        end else begin
                            tx_q <= {tx_q[6:0], 1'b0};
                            bit_q <= bit_q + 4'h1;
                        end
                    end
                end
                trs_pkg::ST_TX_ACK: begin
                    if (nack_seen) begin
                        state_q <= trs_pkg::ST_IGNORE;
                    end else if (scl_fall) begin
                        state_q <= trs_pkg::ST_TX;
                        tx_q <= next_byte;
                        bit_q <= 4'h1;
                        if (txcnt_q != `TRS_TX_LEN) begin
                            txcnt_q <= txcnt_q + 7'h01;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ************************
    // Data pin driver
    // ************************
    always_ff @(posedge clock) begin
        if (!rstn) begin
            sda_oe_n_q <= 1'b1;
            sda_out_q <= 1'b0;
        end else if (start_det || stop_det) begin
            sda_oe_n_q <= 1'b1;
        end else if (ack_now) begin
            sda_oe_n_q <= 1'b0;
        end else if (load_now) begin
            sda_oe_n_q <= next_byte[7];
        end else if (scl_fall && state_q == trs_pkg::ST_TX) begin
            sda_oe_n_q <= (bit_q == `TRS_BYTE_BITS) ? 1'b1 : tx_q[6];
        end else if (scl_fall) begin
            sda_oe_n_q <= 1'b1;
        end
    end

    // ************************
    // Request session
    // ************************
    always_ff @(posedge clock) begin
        if (!rstn) begin
            csum_ok_q <= 1'b0;
            armed_q <= 1'b0;
            build_q <= 1'b0;
            flush_q <= 1'b0;
        end else begin
            build_q <= 1'b0;
            flush_q <= 1'b0;
            if (start_det) begin
                csum_ok_q <= 1'b0;
            end else if (ack_now && state_q == trs_pkg::ST_CSUM) begin
                csum_ok_q <= 1'b1;
            end else if (stop_det && csum_ok_q) begin
                csum_ok_q <= 1'b0;
                armed_q <= 1'b1;
                build_q <= 1'b1;
                flush_q <= 1'b1;
            end
            if (nack_seen) begin
                armed_q <= 1'b0;
                flush_q <= 1'b1;
            end
        end
    end

    assign sda_out = sda_out_q;
    assign sda_oe_n = sda_oe_n_q;
    assign frame_ready = armed_q;

    // ************************
    // Frame path
    // ************************
    trs_frame_builder u_builder (
        .clock(clock),
        .rstn(rstn),
        .start(build_q),
        .abort(flush_q),
        .cmd_code(cmd_q),
        .card_temp(card_temp),
        .main_12v_output_volt(main_12v_output_volt),
        .aux_3v3_output_volt(aux_3v3_output_volt),
        .main_12v_output_curr(main_12v_output_curr),
        .aux_3v3_output_curr(aux_3v3_output_curr),
        .part_string(part_string),
        .serial_bcd(serial_bcd),
        .date_code(date_code),
        .hw_rev(hw_rev),
        .fw_rev(fw_rev),
        .out_s(bld_s)
    );

    trs_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clock(clock),
        .rstn(rstn),
        // A new request drops unread bytes of an older frame
        .flush(flush_q),
        .in_s(bld_s),
        .out_s(fifo_s)
    );

    // ************************
    // Checking helpers
    // ************************
    always_ff @(posedge clock) begin
        if (!rstn) begin
            gap_q <= 8'h00;
            gap_seen_q <= 1'b0;
        end else if (scl_rise) begin
            gap_q <= 8'h01;
            gap_seen_q <= !start_det;
        end else begin
            if (gap_q != 8'hFF) begin
                gap_q <= gap_q + 8'h01;
            end
            if (stop_det) begin
                gap_seen_q <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    AST_SCL_RATE: assert property (
        scl_rise && gap_seen_q |-> gap_q >= 8'(SCL_MIN_CYC))
        else $error("bus clock faster than the allowed rate");
    AST_ADDR_MISS: assert property (
        byte_done && state_q == trs_pkg::ST_ADDR && shift_q[7:4] != `TRS_ADDR_HI
        |=> sda_oe_n_q && state_q == trs_pkg::ST_IGNORE)
        else $error("foreign address was acknowledged");
    AST_SLOT_ORDER: assert property (
        ack_now && state_q == trs_pkg::ST_ADDR |-> shift_q[3:1] == slot_s
        && $past(geo_slot_bit2, 3) == shift_q[3])
        else $error("slot bits in wrong order");
    AST_CMD_ACK: assert property (
        byte_done && state_q == trs_pkg::ST_CMD && shift_q == `TRS_CMD_READ
        |=> !sda_oe_n_q && state_q == trs_pkg::ST_CMD_ACK)
        else $error("read command not acknowledged");
    AST_CSUM_NACK: assert property (
        byte_done && state_q == trs_pkg::ST_CSUM && shift_q != `TRS_CMD_CSUM
        |=> sda_oe_n_q ##1 !csum_ok_q)
        else $error("bad checksum byte was accepted");
    AST_BUILD_ON_STOP: assert property (
        build_q |-> $past(stop_det) && $past(csum_ok_q) && armed_q)
        else $error("frame built without a checked request");
    AST_TX_SOURCE: assert property (
        load_now && armed_q && txcnt_q != `TRS_TX_LEN |-> fifo_s.valid)
        else $error("frame byte missing while transmitting");
endmodule
`default_nettype wire

//--- test/trs_master_model.sv
// Two-wire bus master standing in for the system manager
`default_nettype none
module trs_master_model (
    // Bus pins
    output var logic scl,
    output var logic sda_m,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************
    // Bit timing, 800 ns per bit
    // ****************************************
    localparam int QTR = 200;
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    task automatic xfer_bit(input logic d, output logic q);
        sda_m = d;
        #QTR scl = 1'b1;
        #QTR q = sda;
        #QTR scl = 1'b0;
        #QTR;
    endtask
    task automatic start_cond();
        sda_m = 1'b1;
        #QTR scl = 1'b1;
        #QTR sda_m = 1'b0;
        #QTR scl = 1'b0;
        #QTR;
    endtask
    task automatic stop_cond();
        sda_m = 1'b0;
        #QTR scl = 1'b1;
        #QTR sda_m = 1'b1;
        #(2 * QTR);
    endtask
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic q;
        for (int i = 7; i >= 0; i--) xfer_bit(b[i], q);
        xfer_bit(1'b1, ack);
    endtask
    task automatic rd_byte(input logic nack, output logic [7:0] b);
        logic q;
        for (int i = 7; i >= 0; i--) xfer_bit(1'b1, b[i]);
        xfer_bit(nack, q);
    endtask
endmodule
`default_nettype wire

//--- test/tb_top.sv
// Self-checking bench for the telemetry read slave
`include "trs_map.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic scl, sda_m, sda_out, sda_oe_n, frame_ready;
    logic [2:0] slot = 3'h0;
    logic [15:0] card_temp = '0, main_12v_output_volt = '0, aux_3v3_output_volt = '0;
    logic [15:0] main_12v_output_curr = '0, aux_3v3_output_curr = '0;
    logic [15:0] date_code = '0, hw_rev = '0, fw_rev = '0;
    logic [159:0] part_string = '0;
    logic [31:0] serial_bcd = '0;
    logic [7:0] f [0:64];
    logic [7:0] got [0:64];
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    wire logic sda;
    assign sda = sda_m & (sda_oe_n | sda_out);
    trs_master_model trs_master_model_i (.scl(scl), .sda_m(sda_m), .sda(sda));
    // Bench bus clock is 8 system clocks per bit
    trs_telemetry_slave #(.FIFO_DEPTH(16), .SCL_MIN_CYC(8)) trs_telemetry_slave_i (
        .clock, .rstn, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe_n,
        .geo_slot_bit2(slot[2]), .geo_slot_bit1(slot[1]), .geo_slot_bit0(slot[0]),
        .card_temp, .main_12v_output_volt, .aux_3v3_output_volt, .main_12v_output_curr,
        .aux_3v3_output_curr, .part_string, .serial_bcd, .date_code, .hw_rev, .fw_rev,
        .frame_ready);
    // ****************************************
    // Clock, watchdog and helpers
    // ****************************************
    always #50 clock = ~clock;
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            mismatches = mismatches + 1;
            end_of_test();
        end
    end
    task automatic end_of_test();
        if (mismatches == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        #37;
    endtask
    task automatic load(input logic [7:0] k, input logic [2:0] v);
        @(posedge clock);
        slot <= v;
        card_temp <= {8'hFF, k};
        main_12v_output_volt <= {k, 8'h12};
        aux_3v3_output_volt <= {k, 8'h33};
        main_12v_output_curr <= {8'hC1, k};
        aux_3v3_output_curr <= {8'hC3, k};
        serial_bcd <= {k, 24'h012345};
        date_code <= 16'h3518;
        hw_rev <= {8'h2D, k};
        fw_rev <= {k, 8'h10};
        for (int j = 0; j < 20; j++) part_string[8 * j +: 8] <= k + 8'(j);
        idle(10);
    endtask
    task automatic build();
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 65; i++) f[i] = 8'h00;
        f[0] = `TRS_CMD_READ;
        {f[2], f[3]} = card_temp;
        {f[4], f[5]} = main_12v_output_volt;
        {f[6], f[7]} = aux_3v3_output_volt;
        {f[16], f[17]} = main_12v_output_curr;
        {f[18], f[19]} = aux_3v3_output_curr;
        for (int j = 0; j < 20; j++) f[32 + j] = part_string[159 - 8 * j -: 8];
        for (int j = 0; j < 4; j++) f[52 + j] = serial_bcd[31 - 8 * j -: 8];
        {f[56], f[57]} = date_code;
        {f[58], f[59]} = hw_rev;
        {f[60], f[61]} = fw_rev;
        f[62] = `TRS_RSVD_BYTE;
        for (int i = 0; i < 63; i++) s = s + f[i];
        f[63] = 8'h00 - s;
    endtask
    task automatic req(input logic [6:0] a, input logic [7:0] c, input logic [7:0] s,
                       input logic [2:0] e);
        logic k;
        trs_master_model_i.start_cond();
        trs_master_model_i.wr_byte({a, 1'b0}, k);
        chk({7'h00, k}, {7'h00, e[2]});
        trs_master_model_i.wr_byte(c, k);
        chk({7'h00, k}, {7'h00, e[1]});
        trs_master_model_i.wr_byte(s, k);
        chk({7'h00, k}, {7'h00, e[0]});
        trs_master_model_i.stop_cond();
        idle(150);
    endtask
    task automatic rd(input int first, input int n, input logic exp_nack);
        logic k;
        trs_master_model_i.start_cond();
        trs_master_model_i.wr_byte({`TRS_ADDR_HI, slot, 1'b1}, k);
        chk({7'h00, k}, {7'h00, exp_nack});
        for (int i = first; i < first + n; i++) begin
            // Long SCL low lets the FIFO fill up
            if (i == 4) begin
                idle(300);
                chk({7'h00, frame_ready}, 8'h01);
            end
            trs_master_model_i.rd_byte(i == 64, got[i]);
        end
        trs_master_model_i.stop_cond();
        idle(150);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        chk({7'h00, sda_oe_n}, 8'h01);
        chk({7'h00, sda_out}, 8'h00);
        chk({7'h00, frame_ready}, 8'h00);
    endtask
    task automatic t_slots();
        for (int v = 0; v < 8; v++) begin
            load(8'(v), 3'(v));
            req({`TRS_ADDR_HI, 3'(v)}, `TRS_CMD_READ, `TRS_CMD_CSUM ^ 8'h01, 3'b001);
            req({`TRS_ADDR_HI, 3'(v) ^ (3'h1 << (v % 3))}, `TRS_CMD_READ, `TRS_CMD_CSUM,
                3'b111);
        end
        req({`TRS_ADDR_HI, slot}, 8'h22, `TRS_CMD_CSUM, 3'b011);
        chk({7'h00, frame_ready}, 8'h00);
        rd(0, 0, 1'b1);
    endtask
    task automatic t_full();
        logic [7:0] s;
        s = 8'h00;
        load(8'h98, 3'h5);
        req({`TRS_ADDR_HI, slot}, `TRS_CMD_READ, `TRS_CMD_CSUM, 3'b000);
        build();
        chk({7'h00, frame_ready}, 8'h01);
        rd(0, 65, 1'b0);
        chk({7'h00, frame_ready}, 8'h00);
        for (int i = 0; i < 65; i++) begin
            chk(got[i], f[i]);
            if (i < 64) s = s + got[i];
        end
        chk(s, 8'h00);
        rd(0, 0, 1'b1);
    endtask
    initial begin
        repeat (8) @(posedge clock);
        t_reset();
        rstn <= 1'b1;
        idle(10);
        t_slots();
        t_full();
        end_of_test();
    end
endmodule
`default_nettype wire
